/* File: rtl/cefm_unit.sv */
// Event flag latching and interrupt masking for the charger.
// Assumes status inputs and register strobes come from logic on the same clock.
//
// Function
// - General flags clear after host reads them
// - Fault flags clear after host reads them
// - Power-good flag sets on any toggle
// - Input current regulation flag sets on rise
// - Input voltage regulation flag sets on rise
// - Thermal regulation flag sets on rise
// - Watchdog flag sets on watchdog status rise
// - Termination flag sets on termination rise
// - Charge state flag sets on field change
// - Reserved flag and mask bits read zero
// - Input overvoltage flag sets on rise
// - Thermal shutdown flag sets on rise
// - Battery overvoltage flag sets on rise
// - Flying capacitor fault flag sets on rise
// - Safety timer flag sets on expiry rise
// - Capacitor precondition flag sets on rise
// - Weak source flag sets on rise
// - Power-good mask gates its pulse
// - Regulation masks gate their entry pulses
// - Watchdog mask gates its pulse
// - Termination mask gates its pulse
// - Charge state mask gates its pulse
// - Fault mask bits gate matching fault pulses
// - Charge codes idle, CC and taper
`timescale 1ns/1ps

module cefm_unit (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  clkEn,
  input  wire logic                  regDefaultsReset,
  input  wire logic [7:0]            regAddr,
  input  wire logic                  regRead,
  input  wire logic                  regWrite,
  input  wire logic [7:0]            regWdata,
  input  wire logic                  powerGood,
  input  wire logic                  inputCurrentRegulation,
  input  wire logic                  inputVoltageRegulation,
  input  wire logic                  thermalRegulation,
  input  wire logic                  watchdogExpiredStatus,
  input  wire logic                  chargeTermination,
  input  wire cefm_pkg::cefm_chg_t   chargeStateField,
  input  wire logic                  inputOvervoltage,
  input  wire logic                  thermalShutdown,
  input  wire logic                  batteryOvervoltage,
  input  wire logic                  flyingCapFault,
  input  wire logic                  safetyTimerExpired,
  input  wire logic                  capPreconditionStatus,
  input  wire logic                  weakSourceStatus,
  output logic [7:0]                 regRdata_q,
  output logic                       intPulse_q
);
  import cefm_pkg::*;

  // Packed status, laid out like the flag registers
  logic [7:0] genStat;
  logic [7:0] faultStat;
  // Previous samples for edge detection
  logic [7:0] genPrev_q;
  logic [7:0] faultPrev_q;
  logic [2:0] chgPrev_q;
  // Low until the first sample, so existing levels make no event
  logic       primed_q;
  // Events detected this cycle
  logic       chgChange;
  logic [7:0] genEvt;
  logic [7:0] faultEvt;
  // Flag and mask registers
  logic [7:0] genFlag_q;
  logic [7:0] genFlag_d;
  logic [7:0] faultFlag_q;
  logic [7:0] faultFlag_d;
  logic [7:0] genMask_q;
  logic [7:0] faultMask_q;
  // Clear-on-read strobes
  logic       genClr;
  logic       faultClr;
  // Unmasked events
  logic       intHit;

  // Pack status; reserved positions tie low
  assign genStat = {powerGood, inputCurrentRegulation, inputVoltageRegulation,
                    thermalRegulation, watchdogExpiredStatus, chargeTermination,
                    2'b00};
  assign faultStat = {inputOvervoltage, thermalShutdown, batteryOvervoltage,
                      flyingCapFault, safetyTimerExpired, capPreconditionStatus,
                      weakSourceStatus, 1'b0};

  // Any code change counts, reserved codes included
  assign chgChange = (chargeStateField != chgPrev_q);

  // Event detection
  always_comb begin
    genEvt   = 8'h00;
    faultEvt = 8'h00;
    if (primed_q) begin
      // Power good fires on both edges
      genEvt[CEFM_PG_BIT]   = genStat[CEFM_PG_BIT] ^ genPrev_q[CEFM_PG_BIT];
      // Regulation entries fire on rising edges
      genEvt[CEFM_ICR_BIT]  = genStat[CEFM_ICR_BIT] & ~genPrev_q[CEFM_ICR_BIT];
      genEvt[CEFM_IVR_BIT]  = genStat[CEFM_IVR_BIT] & ~genPrev_q[CEFM_IVR_BIT];
      genEvt[CEFM_TR_BIT]   = genStat[CEFM_TR_BIT] & ~genPrev_q[CEFM_TR_BIT];
      // Watchdog and termination rising edges
      genEvt[CEFM_WD_BIT]   = genStat[CEFM_WD_BIT] & ~genPrev_q[CEFM_WD_BIT];
      genEvt[CEFM_TERM_BIT] = genStat[CEFM_TERM_BIT] & ~genPrev_q[CEFM_TERM_BIT];
      genEvt[CEFM_CHG_BIT]  = chgChange;
      // All fault events are rising edges
      faultEvt = faultStat & ~faultPrev_q & CEFM_FAULT_VALID;
    end
  end

  // Edge history; the watchdog does not touch it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      genPrev_q   <= 8'h00;
      faultPrev_q <= 8'h00;
      chgPrev_q   <= 3'h0;
      primed_q    <= 1'b0;
    end else if (clkEn) begin
      genPrev_q   <= genStat;
      faultPrev_q <= faultStat;
      chgPrev_q   <= chargeStateField;
      primed_q    <= 1'b1;
    end
  end

  // Host reads of the flag registers clear them
  assign genClr   = regRead && (regAddr == CEFM_GEN_FLAG_ADDR);
  assign faultClr = regRead && (regAddr == CEFM_FAULT_FLAG_ADDR);

  // One flag flop per bit; a same-cycle event beats the read clear
  for (genvar i = 0; i < 8; i++) begin : g_flag
    // Flags latch whatever the mask says defaults reset wins
    always_comb begin
      genFlag_d[i]   = regDefaultsReset ? CEFM_FLAG_RESET[i]
                     : ((genFlag_q[i] & ~genClr) | genEvt[i]) & CEFM_GEN_VALID[i];
      faultFlag_d[i] = regDefaultsReset ? CEFM_FLAG_RESET[i]
                     : ((faultFlag_q[i] & ~faultClr) | faultEvt[i]) & CEFM_FAULT_VALID[i];
    end
    // Flag storage
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        genFlag_q[i]   <= CEFM_FLAG_RESET[i];
        faultFlag_q[i] <= CEFM_FLAG_RESET[i];
      end else if (clkEn) begin
        genFlag_q[i]   <= genFlag_d[i];
        faultFlag_q[i] <= faultFlag_d[i];
      end
    end
  end

  // Mask registers; reserved bits never store
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      genMask_q   <= CEFM_MASK_RESET;
      faultMask_q <= CEFM_MASK_RESET;
    end else if (clkEn) begin
      if (regDefaultsReset) begin
        // Defaults reset beats a write in the same cycle
        genMask_q   <= CEFM_MASK_RESET;
        faultMask_q <= CEFM_MASK_RESET;
      end else if (regWrite) begin
        if (regAddr == CEFM_GEN_MASK_ADDR) begin
          genMask_q <= regWdata & CEFM_GEN_VALID;
        end
        if (regAddr == CEFM_FAULT_MASK_ADDR) begin
          faultMask_q <= regWdata & CEFM_FAULT_VALID;
        end
      end
    end
  end

  // Read data shows the values before any clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      regRdata_q <= CEFM_RDATA_RESET;
    end else if (clkEn && regRead) begin
      unique case (regAddr)
        CEFM_GEN_FLAG_ADDR:   regRdata_q <= genFlag_q;
        CEFM_FAULT_FLAG_ADDR: regRdata_q <= faultFlag_q;
        CEFM_GEN_MASK_ADDR:   regRdata_q <= genMask_q;
        CEFM_FAULT_MASK_ADDR: regRdata_q <= faultMask_q;
        // Unmapped offsets answer zero
        default:              regRdata_q <= 8'h00;
      endcase
    end
  end

  // Mask one means silent, zero means pulse
  assign intHit = |(genEvt & ~genMask_q) || |(faultEvt & ~faultMask_q);

  // Interrupt pulse; events in one cycle merge into one pulse
  // Limitation: with clkEn low a pulse in flight is held, not dropped
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      intPulse_q <= 1'b0;
    end else if (clkEn) begin
      intPulse_q <= intHit;
    end
  end

  // Checks on the flag, mask and pulse behaviour
  gen_read_clear_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && genClr && genEvt == 8'h00 |=> genFlag_q == 8'h00)
    else $error("general flags not cleared by read");

  fault_read_clear_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && faultClr && faultEvt == 8'h00 |=> faultFlag_q == 8'h00)
    else $error("fault flags not cleared by read");

  pg_toggle_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && primed_q && !regDefaultsReset && powerGood != genPrev_q[CEFM_PG_BIT]
    |=> genFlag_q[CEFM_PG_BIT])
    else $error("power good toggle not latched");

  icr_rise_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && primed_q && !regDefaultsReset && $rose(inputCurrentRegulation)
    && $past(clkEn) |=> genFlag_q[CEFM_ICR_BIT])
    else $error("current regulation rise not latched");

  ivr_rise_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && primed_q && !regDefaultsReset && inputVoltageRegulation
    && !genPrev_q[CEFM_IVR_BIT] |=> genFlag_q[CEFM_IVR_BIT])
    else $error("voltage regulation rise not latched");

  tr_rise_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && primed_q && !regDefaultsReset && thermalRegulation
    && !genPrev_q[CEFM_TR_BIT] |=> genFlag_q[CEFM_TR_BIT])
    else $error("thermal regulation rise not latched");

  wd_rise_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && !genFlag_q[CEFM_WD_BIT] && !watchdogExpiredStatus ##1
    clkEn && !genFlag_q[CEFM_WD_BIT] && !watchdogExpiredStatus
    |=> genFlag_q[CEFM_WD_BIT] == 1'b0)
    else $error("watchdog flag set without a rise");

  term_rise_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && primed_q && !regDefaultsReset && chargeTermination
    && !genPrev_q[CEFM_TERM_BIT] |=> genFlag_q[CEFM_TERM_BIT])
    else $error("termination rise not latched");

  chg_change_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && primed_q && !regDefaultsReset && chargeStateField != chgPrev_q
    |=> genFlag_q[CEFM_CHG_BIT])
    else $error("charge state change not latched");

  reserved_zero_a: assert property (@(posedge clock) disable iff (rst)
    genFlag_q[1] == 1'b0 && faultFlag_q[0] == 1'b0
    && genMask_q[1] == 1'b0 && faultMask_q[0] == 1'b0)
    else $error("reserved bit reads one");

  ovp_rise_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && primed_q && !regDefaultsReset && inputOvervoltage
    && !faultPrev_q[CEFM_OVP_BIT] |=> faultFlag_q[CEFM_OVP_BIT])
    else $error("input overvoltage rise not latched");

  tsd_rise_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && primed_q && !regDefaultsReset && thermalShutdown
    && !faultPrev_q[CEFM_TSD_BIT] |=> faultFlag_q[CEFM_TSD_BIT])
    else $error("thermal shutdown rise not latched");

  bovp_rise_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && primed_q && !regDefaultsReset && batteryOvervoltage
    && !faultPrev_q[CEFM_BOVP_BIT] |=> faultFlag_q[CEFM_BOVP_BIT])
    else $error("battery overvoltage rise not latched");

  cfly_rise_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && primed_q && !regDefaultsReset && flyingCapFault
    && !faultPrev_q[CEFM_CFLY_BIT] |=> faultFlag_q[CEFM_CFLY_BIT])
    else $error("flying capacitor rise not latched");

  tmr_rise_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && primed_q && !regDefaultsReset && safetyTimerExpired
    && !faultPrev_q[CEFM_TMR_BIT] |=> faultFlag_q[CEFM_TMR_BIT])
    else $error("safety timer rise not latched");

  cap_rise_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && primed_q && !regDefaultsReset && capPreconditionStatus
    && !faultPrev_q[CEFM_CAP_BIT] |=> faultFlag_q[CEFM_CAP_BIT])
    else $error("capacitor precondition rise not latched");

  weak_rise_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && primed_q && !regDefaultsReset && weakSourceStatus
    && !faultPrev_q[CEFM_WEAK_BIT] |=> faultFlag_q[CEFM_WEAK_BIT])
    else $error("weak source rise not latched");

  pg_pulse_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && genEvt[CEFM_PG_BIT] && !genMask_q[CEFM_PG_BIT] |=> intPulse_q)
    else $error("unmasked power good gave no pulse");

  reg_mask_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && (genEvt[6:4] & ~genMask_q[6:4]) != 3'h0 |=> intPulse_q)
    else $error("unmasked regulation entry gave no pulse");

  watchdog_event_mask_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && genEvt == 8'h08 && genMask_q[CEFM_WD_BIT] && faultEvt == 8'h00
    |=> !intPulse_q)
    else $error("masked watchdog event pulsed");

  term_mask_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && genEvt[CEFM_TERM_BIT] && !genMask_q[CEFM_TERM_BIT] |=> intPulse_q)
    else $error("unmasked termination gave no pulse");

  chg_mask_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && genEvt == 8'h01 && genMask_q[CEFM_CHG_BIT] && faultEvt == 8'h00
    |=> !intPulse_q)
    else $error("masked charge state change pulsed");

  fault_mask_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && genEvt == 8'h00 && faultEvt != 8'h00
    |=> intPulse_q == $past((faultEvt & ~faultMask_q) != 8'h00))
    else $error("fault pulse disagrees with mask");

  latch_masked_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && !regDefaultsReset && genEvt[CEFM_PG_BIT] && genMask_q[CEFM_PG_BIT]
    |=> genFlag_q[CEFM_PG_BIT])
    else $error("masked event not latched");

  defaults_reset_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && regDefaultsReset |=> genFlag_q == 8'h00 && faultFlag_q == 8'h00
    && genMask_q == 8'h00 && faultMask_q == 8'h00)
    else $error("defaults reset left state");

  wd_set_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && primed_q && !regDefaultsReset && watchdogExpiredStatus
    && !genPrev_q[CEFM_WD_BIT] |=> genFlag_q[CEFM_WD_BIT])
    else $error("watchdog rise not latched");

  wd_pulse_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && genEvt[CEFM_WD_BIT] && !genMask_q[CEFM_WD_BIT] |=> intPulse_q)
    else $error("unmasked watchdog event gave no pulse");

  chg_pulse_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && genEvt[CEFM_CHG_BIT] && !genMask_q[CEFM_CHG_BIT] |=> intPulse_q)
    else $error("unmasked charge state change gave no pulse");

  fault_pulse_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && (faultEvt & ~faultMask_q) != 8'h00 |=> intPulse_q)
    else $error("unmasked fault event gave no pulse");

  quiet_pulse_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && genEvt == 8'h00 && faultEvt == 8'h00 |=> !intPulse_q)
    else $error("pulse without an event");

  gen_mask_write_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && !regDefaultsReset && regWrite && regAddr == CEFM_GEN_MASK_ADDR
    |=> genMask_q == $past(regWdata & CEFM_GEN_VALID))
    else $error("general mask write not stored");

  fault_mask_write_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && !regDefaultsReset && regWrite && regAddr == CEFM_FAULT_MASK_ADDR
    |=> faultMask_q == $past(regWdata & CEFM_FAULT_VALID))
    else $error("fault mask write not stored");

  gen_read_data_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && genClr |=> regRdata_q == $past(genFlag_q))
    else $error("general flag read returned wrong data");

  fault_read_data_a: assert property (@(posedge clock) disable iff (rst)
    clkEn && faultClr |=> regRdata_q == $past(faultFlag_q))
    else $error("fault flag read returned wrong data");

  // A low enable must hold the flag, mask, read data and pulse registers; edge history is not checked
  freeze_state_a: assert property (@(posedge clock) disable iff (rst) // Clock enable hold
    !clkEn |=> $stable(genFlag_q) && $stable(faultFlag_q) && $stable(genMask_q)
    && $stable(faultMask_q) && $stable(regRdata_q) && $stable(intPulse_q))
    else $error("state moved with the clock enable low");

endmodule : cefm_unit

/* File: include/cefm_pkg.sv */
// Constants for the charger event flag and mask unit.
// Assumes an 8-bit register address from the serial register engine.
package cefm_pkg;
  // Register offsets
  localparam logic [7:0] CEFM_GEN_FLAG_ADDR   = 8'h09;
  localparam logic [7:0] CEFM_FAULT_FLAG_ADDR = 8'h0A;
  localparam logic [7:0] CEFM_GEN_MASK_ADDR   = 8'h0B;
  localparam logic [7:0] CEFM_FAULT_MASK_ADDR = 8'h0C;
  // Values after reset
  localparam logic [7:0] CEFM_FLAG_RESET = 8'h00;
  localparam logic [7:0] CEFM_MASK_RESET = 8'h00;
  localparam logic [7:0] CEFM_RDATA_RESET = 8'h00;
  // Bits that store; the reserved ones read zero
  localparam logic [7:0] CEFM_GEN_VALID   = 8'hFD;
  localparam logic [7:0] CEFM_FAULT_VALID = 8'hFE;
  // Field positions, general registers
  localparam int CEFM_PG_BIT   = 7;
  localparam int CEFM_ICR_BIT  = 6;
  localparam int CEFM_IVR_BIT  = 5;
  localparam int CEFM_TR_BIT   = 4;
  localparam int CEFM_WD_BIT   = 3;
  localparam int CEFM_TERM_BIT = 2;
  localparam int CEFM_CHG_BIT  = 0;
  // Field positions, fault registers
  localparam int CEFM_OVP_BIT  = 7;
  localparam int CEFM_TSD_BIT  = 6;
  localparam int CEFM_BOVP_BIT = 5;
  localparam int CEFM_CFLY_BIT = 4;
  localparam int CEFM_TMR_BIT  = 3;
  localparam int CEFM_CAP_BIT  = 2;
  localparam int CEFM_WEAK_BIT = 1;
  // Charge state codes; the rest are reserved
  typedef enum logic [2:0] {
    CEFM_CHG_IDLE  = 3'h0,
    CEFM_CHG_CC    = 3'h3,
    CEFM_CHG_TAPER = 3'h4
  } cefm_chg_t;
endpackage : cefm_pkg

/* File: verification/cefm_host_model.sv */
// Host processor model: single-cycle register reads and writes.
// Assumes the unit takes one strobe per access on a rising clock edge.
`timescale 1ns/1ps

module cefm_host_model (
  input  wire logic       clock,
  input  wire logic [7:0] regRdata_q,
  output logic      [7:0] regAddr,
  output logic            regRead,
  output logic            regWrite,
  output logic      [7:0] regWdata
);
  import cefm_pkg::*;

  // Idle bus: strobes low, address and data parked on a junk pattern
  initial begin
    regAddr  = 8'hA5;
    regRead  = 1'b0;
    regWrite = 1'b0;
    regWdata = 8'h5A;
  end

  // One write access, strobe held for exactly one taken edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    regAddr  <= ~a;  // Released lines stop showing the old value
    regWdata <= ~d;
  endtask : wr

  // One read access; data is taken once the registered answer has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    regAddr <= ~a;
    @(negedge clock);
    d = regRdata_q;  // Answer is registered on the taken edge and sampled half a cycle later
  endtask : rd
endmodule : cefm_host_model

/* File: verification/cefm_unit_tb.sv */
// Self-checking bench for the event flag and mask unit.
// Assumes the host model drives the register strobes; bench drives status levels.
`timescale 1ns/1ps

module cefm_unit_tb;
  import cefm_pkg::*;

  logic       clock = 1'b0;        // 20 MHz system clock
  logic       rst = 1'b1;          // Async reset, held at start
  logic       defRst = 1'b0;       // Register-defaults reset
  logic       clkEn = 1'b1;        // Clock enable, dropped once to check the freeze
  logic [7:0] genS = 8'h00;        // General status levels, flag bit order
  logic [7:0] fltS = 8'h00;        // Fault status levels, flag bit order
  cefm_chg_t  chgS = CEFM_CHG_IDLE; // Charge state code
  logic [7:0] regAddr;
  logic       regRead;
  logic       regWrite;
  logic [7:0] regWdata;
  logic [7:0] regRdata_q;
  logic       intPulse_q;
  int         failCount = 0;       // Mismatches seen
  int         nChecks = 0;         // Comparisons made
  int         cycles = 0;          // Hang guard

  always #25 clock = ~clock;

  cefm_unit cefm_unit_i (
    .clock(clock), .rst(rst), .clkEn(clkEn), .regDefaultsReset(defRst),
    .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite), .regWdata(regWdata),
    .powerGood(genS[7]), .inputCurrentRegulation(genS[6]),
    .inputVoltageRegulation(genS[5]), .thermalRegulation(genS[4]),
    .watchdogExpiredStatus(genS[3]), .chargeTermination(genS[2]),
    .chargeStateField(chgS), .inputOvervoltage(fltS[7]), .thermalShutdown(fltS[6]),
    .batteryOvervoltage(fltS[5]), .flyingCapFault(fltS[4]),
    .safetyTimerExpired(fltS[3]), .capPreconditionStatus(fltS[2]),
    .weakSourceStatus(fltS[1]), .regRdata_q(regRdata_q), .intPulse_q(intPulse_q)
  );

  cefm_host_model cefm_host_model_i (
    .clock(clock), .regRdata_q(regRdata_q), .regAddr(regAddr),
    .regRead(regRead), .regWrite(regWrite), .regWdata(regWdata)
  );

  // Single comparison point; unknowns never match
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    nChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Register read compared against an expected value
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    cefm_host_model_i.rd(a, d);
    chk(d, exp);
  endtask : rdChk

  // Apply new levels, check the pulse, then read flags (clear on read)
  task automatic evt(input logic [7:0] g, input logic [7:0] f, input cefm_chg_t c,
                     input logic [7:0] eg, input logic [7:0] ef, input logic ei);
    @(posedge clock);
    genS <= g;
    fltS <= f;
    chgS <= c;
    @(posedge clock);
    @(negedge clock);
    chk({7'h00, intPulse_q}, {7'h00, ei});
    @(negedge clock);
    chk({7'h00, intPulse_q}, 8'h00);
    rdChk(CEFM_GEN_FLAG_ADDR, eg);
    rdChk(CEFM_FAULT_FLAG_ADDR, ef);
    rdChk(CEFM_GEN_FLAG_ADDR, 8'h00);
    rdChk(CEFM_FAULT_FLAG_ADDR, 8'h00);
  endtask : evt

  // Reset values, reserved bits, refused writes and unmapped reads
  task automatic test_regs();
    rdChk(CEFM_GEN_MASK_ADDR, CEFM_MASK_RESET);
    rdChk(CEFM_FAULT_MASK_ADDR, CEFM_MASK_RESET);
    cefm_host_model_i.wr(CEFM_GEN_MASK_ADDR, 8'hFF);
    cefm_host_model_i.wr(CEFM_FAULT_MASK_ADDR, 8'hFF);
    cefm_host_model_i.wr(CEFM_GEN_FLAG_ADDR, 8'hFF);
    rdChk(CEFM_GEN_MASK_ADDR, 8'hFD);
    rdChk(CEFM_FAULT_MASK_ADDR, 8'hFE);
    rdChk(CEFM_GEN_FLAG_ADDR, 8'h00);
    rdChk(8'h0D, 8'h00);
  endtask : test_regs

  // Each general event alone, every other mask bit set
  task automatic test_gen();
    for (int i = 2; i < 8; i++) begin
      cefm_host_model_i.wr(CEFM_GEN_MASK_ADDR, ~(8'h01 << i));
      evt(8'h01 << i, 8'h00, CEFM_CHG_IDLE, 8'h01 << i, 8'h00, 1'b1);
      // Only power-good reacts to a fall
      evt(8'h00, 8'h00, CEFM_CHG_IDLE, (i == 7) ? 8'h80 : 8'h00, 8'h00, i == 7);
    end
    cefm_host_model_i.wr(CEFM_GEN_MASK_ADDR, 8'hFE);
    evt(8'h00, 8'h00, CEFM_CHG_CC, 8'h01, 8'h00, 1'b1);
    evt(8'h00, 8'h00, CEFM_CHG_TAPER, 8'h01, 8'h00, 1'b1);
    evt(8'h00, 8'h00, CEFM_CHG_IDLE, 8'h01, 8'h00, 1'b1);
    evt(8'h00, 8'h00, CEFM_CHG_IDLE, 8'h00, 8'h00, 1'b0);
  endtask : test_gen

  // Each fault event alone on rise, falls ignored
  task automatic test_fault();
    cefm_host_model_i.wr(CEFM_GEN_MASK_ADDR, 8'hFF);
    for (int i = 1; i < 8; i++) begin
      cefm_host_model_i.wr(CEFM_FAULT_MASK_ADDR, ~(8'h01 << i));
      evt(8'h00, 8'h01 << i, CEFM_CHG_IDLE, 8'h00, 8'h01 << i, 1'b1);
      evt(8'h00, 8'h00, CEFM_CHG_IDLE, 8'h00, 8'h00, 1'b0);
    end
  endtask : test_fault

  // Everything masked still latches; unmasked events merge into one pulse
  task automatic test_masks();
    cefm_host_model_i.wr(CEFM_FAULT_MASK_ADDR, 8'hFF);
    evt(8'hFC, 8'hFE, CEFM_CHG_CC, 8'hFD, 8'hFE, 1'b0);
    evt(8'h00, 8'h00, CEFM_CHG_IDLE, 8'h81, 8'h00, 1'b0);
    cefm_host_model_i.wr(CEFM_GEN_MASK_ADDR, 8'h00);
    cefm_host_model_i.wr(CEFM_FAULT_MASK_ADDR, 8'h00);
    evt(8'hFC, 8'hFE, CEFM_CHG_TAPER, 8'hFD, 8'hFE, 1'b1);
  endtask : test_masks

  // Defaults reset drops latched flags and masks
  task automatic test_defaults();
    cefm_host_model_i.wr(CEFM_GEN_MASK_ADDR, 8'h5A);
    cefm_host_model_i.wr(CEFM_FAULT_MASK_ADDR, 8'h3C);
    @(posedge clock);
    genS <= 8'h00;
    fltS <= 8'h00;
    @(posedge clock);
    genS <= 8'h08;                      // Watchdog expiry must keep the masks
    rdChk(CEFM_GEN_MASK_ADDR, 8'h58);
    rdChk(CEFM_FAULT_MASK_ADDR, 8'h3C);
    @(posedge clock);
    defRst <= 1'b1;
    @(posedge clock);
    defRst <= 1'b0;
    rdChk(CEFM_GEN_FLAG_ADDR, CEFM_FLAG_RESET);
    rdChk(CEFM_FAULT_FLAG_ADDR, CEFM_FLAG_RESET);
    rdChk(CEFM_GEN_MASK_ADDR, CEFM_MASK_RESET);
    rdChk(CEFM_FAULT_MASK_ADDR, CEFM_MASK_RESET);
  endtask : test_defaults

  // Enable low hides a fault rise; it shows once the enable returns
  task automatic test_freeze();
    @(posedge clock);
    clkEn <= 1'b0;
    fltS  <= 8'h40;
    @(posedge clock);
    @(negedge clock);
    chk({7'h00, intPulse_q}, 8'h00);
    @(posedge clock);
    clkEn <= 1'b1;
    @(posedge clock);
    @(negedge clock);
    chk({7'h00, intPulse_q}, 8'h01);
    rdChk(CEFM_FAULT_FLAG_ADDR, 8'h40);
    @(posedge clock);
    fltS <= 8'h00;
  endtask : test_freeze

  // Verdict and end of run
  task automatic give_verdict();
    if (failCount == 0 && nChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  // Hang guard: the full sequence needs well under this many cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failCount++;
      give_verdict();
    end
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    test_regs();
    test_gen();
    test_fault();
    test_masks();
    test_defaults();
    test_freeze();
    give_verdict();
  end
endmodule : cefm_unit_tb
